//--- pkg/dtpc_consts.svh
`ifndef DTPC_CONSTS_SVH
`define DTPC_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses on the register port)
// ----------------------------------------------------------------------
`define DTPC_REF_LIMIT_OFS  8'h00
`define DTPC_DES_LIMIT_OFS  8'h04
`define DTPC_COUNT_OFS      8'h08
`define DTPC_STATUS_OFS     8'h0c
`define DTPC_MASK_OFS       8'h10
`define DTPC_DI_FSEL_OFS    8'h20
`define DTPC_DO_FSEL_OFS    8'h40
`define DTPC_REG_STRIDE     8'h04

// ----------------------------------------------------------------------
// terminal counts and field positions
// ----------------------------------------------------------------------
`define DTPC_NUM_DI         8
`define DTPC_NUM_DO         5
`define DTPC_ST_REF_REACH   0
`define DTPC_ST_DES_REACH   1
`define DTPC_ST_CNT_CLEAR   2
`define DTPC_ST_WIDTH       3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define DTPC_LIMIT_RST      16'h03e8
`define DTPC_FSEL_RST       8'h00
`define DTPC_MASK_RST       3'h0

// ----------------------------------------------------------------------
// terminal function codes
// ----------------------------------------------------------------------
`define DTPC_FN_COUNT_IN    8'h1b
`define DTPC_FN_COUNT_CLR   8'h1c
`define DTPC_FN_REF_REACH   8'h1d
`define DTPC_FN_DES_REACH   8'h1e

`endif

//--- pkg/dtpc_pkg.sv
package dtpc_pkg;
    // power-up phase: restore retained count, then run
    typedef enum logic [0:0] {
        DTPC_RESTORE = 1'b0,
        DTPC_RUN     = 1'b1
    } dtpc_phase_e;

    typedef logic [7:0]  dtpc_fsel_t;
    typedef logic [15:0] dtpc_count_t;
endpackage

//--- rtl/dtpc_counter.sv
// Strobed register access and the placing of the registers were decided locally.
`include "dtpc_consts.svh"

module dtpc_counter
    import dtpc_pkg::*;
(
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst_b,
    // register port
    input  wire logic [7:0]              regAddr,
    input  wire logic [31:0]             regWrData,
    input  wire logic                    regWr,
    input  wire logic                    regRd,
    output logic      [31:0]             regRdData_r,
    // terminals
    input  wire logic [`DTPC_NUM_DI-1:0] diPin,
    output logic      [`DTPC_NUM_DO-1:0] doPin_r,
    // retained count storage
    input  wire logic [15:0]             nvRestoreCount,
    output logic      [15:0]             nvSaveCount_r,
    output logic                         nvSaveStb_r,
    // interrupt
    output logic                         irq_r
);

    // ------------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------------

    // true when the bus address selects the given register
    function automatic logic addrHit(input logic [7:0] a,
                                     input logic [7:0] ofs);
        addrHit = (a == ofs);
    endfunction

    // mask of input terminals whose function select equals a code
    function automatic logic [`DTPC_NUM_DI-1:0] diMatch(
        input dtpc_fsel_t sel [`DTPC_NUM_DI],
        input dtpc_fsel_t code);
        logic [`DTPC_NUM_DI-1:0] m;
        m = '0;
        for (int i = 0; i < `DTPC_NUM_DI; i++) begin
            m[i] = (sel[i] == code);
        end
        diMatch = m;
    endfunction

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic                    rstMetaB_r;
    logic                    rstSyncB_r;
    logic [`DTPC_NUM_DI-1:0] diMeta_r;
    logic [`DTPC_NUM_DI-1:0] diSync_r;
    logic [`DTPC_NUM_DI-1:0] diPrev_r;
    dtpc_fsel_t              diFsel_r [`DTPC_NUM_DI];
    dtpc_fsel_t              doFsel_r [`DTPC_NUM_DO];
    dtpc_count_t             refLimit_r;
    dtpc_count_t             desLimit_r;
    dtpc_count_t             count_r;
    dtpc_phase_e             phase_r;
    logic [`DTPC_ST_WIDTH-1:0] status_r;
    logic [`DTPC_ST_WIDTH-1:0] mask_r;
    logic                    refReachD_r;
    logic                    desReachD_r;
    logic                    clrAnyD_r;
    logic [`DTPC_NUM_DI-1:0] cntMask;
    logic [`DTPC_NUM_DI-1:0] clrMask;
    logic                    incAny;
    logic                    clrAny;
    logic                    refReach;
    logic                    desReach;
    logic [`DTPC_ST_WIDTH-1:0] stEvent;
    logic [31:0]             rdData_nxt;

    // ------------------------------------------------------------------
    // reset release synchroniser
    // ------------------------------------------------------------------

    // assert at once, release after two clock edges
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMetaB_r <= 1'b0;
            rstSyncB_r <= 1'b0;
        end else begin
            rstMetaB_r <= 1'b1;
            rstSyncB_r <= rstMetaB_r;
        end
    end

    // ------------------------------------------------------------------
    // input terminal synchronisers
    // ------------------------------------------------------------------

    // two flops per pin, then a delayed copy for edge detection
    always_ff @(posedge ref_clk or negedge rstSyncB_r) begin
        if (!rstSyncB_r) begin
            diMeta_r <= '0;
            diSync_r <= '0;
            diPrev_r <= '0;
        end else begin
            diMeta_r <= diPin;
            diSync_r <= diMeta_r;
            diPrev_r <= diSync_r;
        end
    end

    // ------------------------------------------------------------------
    // terminal function select registers
    // ------------------------------------------------------------------

    // one function select per input terminal
    for (genvar gi = 0; gi < `DTPC_NUM_DI; gi++) begin : g_diFsel
        always_ff @(posedge ref_clk or negedge rstSyncB_r) begin
            if (!rstSyncB_r) begin
                diFsel_r[gi] <= `DTPC_FSEL_RST;
            end else if (regWr && addrHit(regAddr,
                         8'(`DTPC_DI_FSEL_OFS + 8'(gi * 4)))) begin
                diFsel_r[gi] <= regWrData[7:0];
            end
        end
    end

    // one function select per output terminal; a single code per
    // terminal means it can never carry both reach functions
    for (genvar go = 0; go < `DTPC_NUM_DO; go++) begin : g_doFsel
        always_ff @(posedge ref_clk or negedge rstSyncB_r) begin
            if (!rstSyncB_r) begin
                doFsel_r[go] <= `DTPC_FSEL_RST;
            end else if (regWr && addrHit(regAddr,
                         8'(`DTPC_DO_FSEL_OFS + 8'(go * 4)))) begin
                doFsel_r[go] <= regWrData[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // count limits
    // ------------------------------------------------------------------

    // writes of zero are out of range and leave the limit unchanged;
    // ordering of the two limits is left to software
    always_ff @(posedge ref_clk or negedge rstSyncB_r) begin
        if (!rstSyncB_r) begin
            refLimit_r <= `DTPC_LIMIT_RST;
            desLimit_r <= `DTPC_LIMIT_RST;
        end else if (regWr && regWrData[15:0] != 16'h0000) begin
            if (addrHit(regAddr, `DTPC_REF_LIMIT_OFS)) begin
                refLimit_r <= regWrData[15:0];
            end
            if (addrHit(regAddr, `DTPC_DES_LIMIT_OFS)) begin
                desLimit_r <= regWrData[15:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // count and reach decode
    // ------------------------------------------------------------------

    // terminals assigned to counting and to clearing
    assign cntMask  = diMatch(diFsel_r, `DTPC_FN_COUNT_IN);
    assign clrMask  = diMatch(diFsel_r, `DTPC_FN_COUNT_CLR);
    // simultaneous edges on several terminals count once
    assign incAny   = |(cntMask & diSync_r & ~diPrev_r);
    assign clrAny   = |(clrMask & diSync_r);
    assign refReach = (count_r >= refLimit_r);
    assign desReach = (count_r >= desLimit_r);

    // power-up phase: one cycle of restore after reset release
    always_ff @(posedge ref_clk or negedge rstSyncB_r) begin
        if (!rstSyncB_r) begin
            phase_r <= DTPC_RESTORE;
        end else begin
            unique case (phase_r)
                DTPC_RESTORE: phase_r <= DTPC_RUN;
                DTPC_RUN:     phase_r <= DTPC_RUN;
            endcase
        end
    end

    // count: restore, clear has priority, else saturating increment;
    // no drive run/stop state gates it
    always_ff @(posedge ref_clk or negedge rstSyncB_r) begin
        if (!rstSyncB_r) begin
            count_r <= 16'h0000;
        end else if (phase_r == DTPC_RESTORE) begin
            count_r <= nvRestoreCount;
        end else if (clrAny) begin
            count_r <= 16'h0000;
        end else if (incAny && count_r < refLimit_r) begin
            count_r <= count_r + 16'h0001;
        end
    end

    // copy of the count for retained storage, strobe on each change
    always_ff @(posedge ref_clk or negedge rstSyncB_r) begin
        if (!rstSyncB_r) begin
            nvSaveCount_r <= 16'h0000;
            nvSaveStb_r   <= 1'b0;
        end else begin
            nvSaveCount_r <= count_r;
            nvSaveStb_r   <= (phase_r == DTPC_RUN) &&
                             (count_r != nvSaveCount_r);
        end
    end

    // ------------------------------------------------------------------
    // output terminals
    // ------------------------------------------------------------------

    // each terminal shows the reach that its function code selects;
    // a reach output can be fed back to the drive stop input
    for (genvar go = 0; go < `DTPC_NUM_DO; go++) begin : g_doPin
        always_ff @(posedge ref_clk or negedge rstSyncB_r) begin
            if (!rstSyncB_r) begin
                doPin_r[go] <= 1'b0;
            end else if (doFsel_r[go] == `DTPC_FN_REF_REACH) begin
                doPin_r[go] <= refReach;
            end else if (doFsel_r[go] == `DTPC_FN_DES_REACH) begin
                doPin_r[go] <= desReach;
            end else begin
                doPin_r[go] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupt status, mask and output
    // ------------------------------------------------------------------

    // edge detectors for reach and clear events
    always_ff @(posedge ref_clk or negedge rstSyncB_r) begin
        if (!rstSyncB_r) begin
            refReachD_r <= 1'b0;
            desReachD_r <= 1'b0;
            clrAnyD_r   <= 1'b0;
        end else begin
            refReachD_r <= refReach;
            desReachD_r <= desReach;
            clrAnyD_r   <= clrAny;
        end
    end

    // events only count once the retained count is in place
    always_comb begin
        stEvent = '0;
        if (phase_r == DTPC_RUN) begin
            stEvent[`DTPC_ST_REF_REACH] = refReach & ~refReachD_r;
            stEvent[`DTPC_ST_DES_REACH] = desReach & ~desReachD_r;
            stEvent[`DTPC_ST_CNT_CLEAR] = clrAny & ~clrAnyD_r;
        end
    end

    // sticky status, write one to clear; a new event wins
    always_ff @(posedge ref_clk or negedge rstSyncB_r) begin
        if (!rstSyncB_r) begin
            status_r <= '0;
        end else if (regWr && addrHit(regAddr, `DTPC_STATUS_OFS)) begin
            status_r <= (status_r & ~regWrData[`DTPC_ST_WIDTH-1:0])
                        | stEvent;
        end else begin
            status_r <= status_r | stEvent;
        end
    end

    // interrupt mask, a one enables the matching status bit
    always_ff @(posedge ref_clk or negedge rstSyncB_r) begin
        if (!rstSyncB_r) begin
            mask_r <= `DTPC_MASK_RST;
        end else if (regWr && addrHit(regAddr, `DTPC_MASK_OFS)) begin
            mask_r <= regWrData[`DTPC_ST_WIDTH-1:0];
        end
    end

    // level interrupt while any unmasked status bit is set
    always_ff @(posedge ref_clk or negedge rstSyncB_r) begin
        if (!rstSyncB_r) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_r & mask_r);
        end
    end

    // ------------------------------------------------------------------
    // register read path
    // ------------------------------------------------------------------

    // read multiplexer; unmapped addresses read zero
    always_comb begin
        rdData_nxt = 32'h0000_0000;
        if (addrHit(regAddr, `DTPC_REF_LIMIT_OFS)) begin
            rdData_nxt = {16'h0000, refLimit_r};
        end else if (addrHit(regAddr, `DTPC_DES_LIMIT_OFS)) begin
            rdData_nxt = {16'h0000, desLimit_r};
        end else if (addrHit(regAddr, `DTPC_COUNT_OFS)) begin
            rdData_nxt = {14'h0000, desReach, refReach, count_r};
        end else if (addrHit(regAddr, `DTPC_STATUS_OFS)) begin
            rdData_nxt = {29'h0000_0000, status_r};
        end else if (addrHit(regAddr, `DTPC_MASK_OFS)) begin
            rdData_nxt = {29'h0000_0000, mask_r};
        end
        for (int i = 0; i < `DTPC_NUM_DI; i++) begin
            if (addrHit(regAddr, 8'(`DTPC_DI_FSEL_OFS + 8'(i * 4)))) begin
                rdData_nxt = {24'h00_0000, diFsel_r[i]};
            end
        end
        for (int i = 0; i < `DTPC_NUM_DO; i++) begin
            if (addrHit(regAddr, 8'(`DTPC_DO_FSEL_OFS + 8'(i * 4)))) begin
                rdData_nxt = {24'h00_0000, doFsel_r[i]};
            end
        end
    end

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge ref_clk or negedge rstSyncB_r) begin
        if (!rstSyncB_r) begin
            regRdData_r <= 32'h0000_0000;
        end else if (regRd) begin
            regRdData_r <= rdData_nxt;
        end else begin
            regRdData_r <= 32'h0000_0000;
        end
    end

endmodule

//--- tb/dtpc_checker.sv
`include "dtpc_consts.svh"

module dtpc_checker
    import dtpc_pkg::*;
(
    // clock and reset
    input wire logic                    ref_clk,
    input wire logic                    rst_b,
    // register port
    input wire logic [7:0]              regAddr,
    input wire logic [31:0]             regWrData,
    input wire logic                    regWr,
    input wire logic                    regRd,
    input wire logic [31:0]             regRdData_r,
    // terminals
    input wire logic [`DTPC_NUM_DI-1:0] diPin,
    input wire logic [`DTPC_NUM_DO-1:0] doPin_r,
    // retained count storage
    input wire logic [15:0]             nvRestoreCount,
    input wire logic [15:0]             nvSaveCount_r,
    input wire logic                    nvSaveStb_r,
    // interrupt
    input wire logic                    irq_r
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // count moves up by exactly one unless restored or cleared
    a_count_step: assert property (
        nvSaveStb_r && nvSaveCount_r != 16'h0 && $past(nvSaveCount_r) != 16'h0
        |-> nvSaveCount_r == $past(nvSaveCount_r) + 16'h1)
        else $error("count step is not one");
    // every change of the count is offered to retained storage
    a_save_on_change: assert property (
        $changed(nvSaveCount_r) |-> nvSaveStb_r)
        else $error("count changed without save strobe");
    a_save_only_change: assert property (
        nvSaveStb_r |-> $changed(nvSaveCount_r))
        else $error("save strobe without new count");
    // limits are at least one, so a zero count shows no reach
    a_zero_no_reach: assert property (
        nvSaveCount_r == 16'h0 |-> doPin_r == 5'h00)
        else $error("reach output active at zero count");
    // outputs move only with the count or a configuration write
    a_reach_cause: assert property (
        $changed(doPin_r) |-> nvSaveStb_r || $past(regWr) || $past(regWr, 2))
        else $error("output terminal changed without cause");
    // reach drops only through a clear or a new configuration
    a_reach_hold: assert property (
        $fell(doPin_r[0]) |->
        nvSaveCount_r == 16'h0 || $past(regWr) || $past(regWr, 2))
        else $error("reach output dropped while count held");
    a_irq_clear_cause: assert property (
        $fell(irq_r) |-> $past(regWr) || $past(regWr, 2))
        else $error("interrupt dropped without a write");
    // read data only in the cycle after a read, upper bits always zero
    a_rd_data_idle: assert property (
        !$past(regRd) |-> regRdData_r == 32'h0)
        else $error("read data outside read cycle");
    a_rd_upper_zero: assert property (
        regRdData_r[31:18] == 14'h0)
        else $error("read data upper bits set");

    // ------------------------------------------------------------------
    // covers
    // ------------------------------------------------------------------
    c_irq_rise: cover property ($rose(irq_r));
    c_both_reach: cover property (doPin_r == 5'h03);
    c_count_clear: cover property (nvSaveStb_r && nvSaveCount_r == 16'h0);
endmodule

bind dtpc_counter dtpc_checker u_chk (
    .ref_clk        (ref_clk),
    .rst_b          (rst_b),
    .regAddr        (regAddr),
    .regWrData      (regWrData),
    .regWr          (regWr),
    .regRd          (regRd),
    .regRdData_r    (regRdData_r),
    .diPin          (diPin),
    .doPin_r        (doPin_r),
    .nvRestoreCount (nvRestoreCount),
    .nvSaveCount_r  (nvSaveCount_r),
    .nvSaveStb_r    (nvSaveStb_r),
    .irq_r          (irq_r)
);

//--- tb/dtpc_partner.sv
module dtpc_partner
    import dtpc_pkg::*;
(
    // clock
    input  wire logic        ref_clk,
    // terminal wiring
    output logic [7:0]       diPin,
    input  wire logic [4:0]  doPin_r,
    output logic             driveStop,
    // retained count storage
    output logic [15:0]      nvRestoreCount,
    input  wire logic [15:0] nvSaveCount_r,
    input  wire logic        nvSaveStb_r
);
    timeunit 1ns;
    timeprecision 1ps;

    dtpc_count_t stored = 16'h0;

    // idle terminals sit low
    initial diPin = 8'h00;

    // ------------------------------------------------------------------
    // pulse source: two cycles high, three low between pulses
    // ------------------------------------------------------------------
    task automatic pulse(input int k, input int n);
        repeat (n) begin
            @(posedge ref_clk) diPin[k] <= 1'b1;
            repeat (2) @(posedge ref_clk);
            diPin[k] <= 1'b0;
            repeat (2) @(posedge ref_clk);
        end
    endtask

    task automatic hold(input int k, input logic v);
        @(posedge ref_clk) diPin[k] <= v;
    endtask

    // nonvolatile store survives the device reset
    always @(posedge ref_clk) begin
        if (nvSaveStb_r) begin
            stored <= nvSaveCount_r;
        end
    end
    assign nvRestoreCount = stored;

    // any reach output wired back to the stop input
    assign driveStop = |doPin_r;
endmodule

//--- tb/dual_threshold_pulse_counter_bench.sv
`include "dtpc_consts.svh"

module dual_threshold_pulse_counter_bench
    import dtpc_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [31:0] regRdData_r;
    logic [7:0]  diPin;
    logic [4:0]  doPin_r;
    logic [15:0] nvRestoreCount;
    logic [15:0] nvSaveCount_r;
    logic        nvSaveStb_r;
    logic        irq_r;
    logic        driveStop;
    int          nFail = 0;
    int          testsRun = 0;

    // 40 MHz clock
    initial forever #12.5 ref_clk = ~ref_clk;

    dtpc_counter dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData_r(regRdData_r), .diPin(diPin), .doPin_r(doPin_r),
        .nvRestoreCount(nvRestoreCount), .nvSaveCount_r(nvSaveCount_r),
        .nvSaveStb_r(nvSaveStb_r), .irq_r(irq_r));

    dtpc_partner u_far (
        .ref_clk(ref_clk), .diPin(diPin), .doPin_r(doPin_r),
        .driveStop(driveStop), .nvRestoreCount(nvRestoreCount),
        .nvSaveCount_r(nvSaveCount_r), .nvSaveStb_r(nvSaveStb_r));

    // ------------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            nFail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask

    // data stands only in the cycle after the read edge
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), exp, regRdData_r);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", testsRun, nFail);
        if (nFail == 0 && testsRun > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge ref_clk);
        // reset values, refused writes, unmapped place
        rd(`DTPC_REF_LIMIT_OFS, {16'h0, `DTPC_LIMIT_RST});
        rd(`DTPC_DES_LIMIT_OFS, {16'h0, `DTPC_LIMIT_RST});
        rd(`DTPC_MASK_OFS, 32'h0);
        rd(`DTPC_DI_FSEL_OFS + 8'h1c, 32'h0);
        rd(8'h60, 32'h0);
        rd(`DTPC_COUNT_OFS, 32'h0);
        wr(`DTPC_REF_LIMIT_OFS, 32'h0);
        rd(`DTPC_REF_LIMIT_OFS, {16'h0, `DTPC_LIMIT_RST});
        wr(`DTPC_REF_LIMIT_OFS, 32'hffff);
        rd(`DTPC_REF_LIMIT_OFS, 32'hffff);
        wr(`DTPC_COUNT_OFS, 32'h7);
        rd(`DTPC_COUNT_OFS, 32'h0);
        // designated limit kept below reference limit
        wr(`DTPC_REF_LIMIT_OFS, 32'h5);
        wr(`DTPC_DES_LIMIT_OFS, 32'h3);
        wr(`DTPC_DI_FSEL_OFS + 8'h08, `DTPC_FN_COUNT_IN);
        wr(`DTPC_DI_FSEL_OFS + 8'h18, `DTPC_FN_COUNT_IN);
        wr(`DTPC_DI_FSEL_OFS + 8'h14, `DTPC_FN_COUNT_CLR);
        wr(`DTPC_DO_FSEL_OFS, `DTPC_FN_REF_REACH);
        wr(`DTPC_DO_FSEL_OFS + 8'h04, `DTPC_FN_DES_REACH);
        wr(`DTPC_DO_FSEL_OFS + 8'h0c, `DTPC_FN_COUNT_IN);
        wr(`DTPC_MASK_OFS, 32'h7);
        // designated threshold reached first
        u_far.pulse(2, 3);
        repeat (8) @(posedge ref_clk);
        rd(`DTPC_COUNT_OFS, 32'h2_0003);
        chk("doPin", 32'h02, {27'h0, doPin_r});
        chk("irq", 32'h1, {31'h0, irq_r});
        rd(`DTPC_STATUS_OFS, 32'h2);
        wr(`DTPC_STATUS_OFS, 32'h2);
        repeat (2) @(posedge ref_clk);
        chk("irq", 32'h0, {31'h0, irq_r});
        // second counter input, count saturates at reference limit
        u_far.pulse(6, 4);
        repeat (8) @(posedge ref_clk);
        rd(`DTPC_COUNT_OFS, 32'h3_0005);
        chk("doPin", 32'h03, {27'h0, doPin_r});
        chk("stop", 32'h1, {31'h0, driveStop});
        // clear level empties the count and drops both reaches
        u_far.hold(5, 1'b1);
        repeat (8) @(posedge ref_clk);
        rd(`DTPC_COUNT_OFS, 32'h0);
        chk("doPin", 32'h00, {27'h0, doPin_r});
        u_far.hold(5, 1'b0);
        repeat (6) @(posedge ref_clk);
        rd(`DTPC_STATUS_OFS, 32'h5);
        wr(`DTPC_STATUS_OFS, 32'h7);
        // count survives a mid-run reset
        u_far.pulse(2, 2);
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(`DTPC_COUNT_OFS, 32'h2);
        rd(`DTPC_REF_LIMIT_OFS, {16'h0, `DTPC_LIMIT_RST});
        // masked event stays quiet until unmasked
        wr(`DTPC_REF_LIMIT_OFS, 32'h3);
        wr(`DTPC_DI_FSEL_OFS + 8'h08, `DTPC_FN_COUNT_IN);
        u_far.pulse(2, 1);
        repeat (8) @(posedge ref_clk);
        rd(`DTPC_COUNT_OFS, 32'h1_0003);
        chk("irq", 32'h0, {31'h0, irq_r});
        wr(`DTPC_MASK_OFS, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk("irq", 32'h1, {31'h0, irq_r});
        finish_test;
    end

    // watchdog
    initial begin
        repeat (20000) @(posedge ref_clk);
        nFail++;
        $display("Error watchdog expected done seen hang");
        finish_test;
    end
endmodule
